// ===== shared/awsc_pkg.sv
// Constants and types for the area wait state control block
package awsc_pkg;

  // ************************************************************
  // Register offsets (byte addresses on the register bus)
  // ************************************************************
  localparam logic [7:0] AWSC_OFS_WAIT   = 8'h00;
  localparam logic [7:0] AWSC_OFS_MODE   = 8'h04;
  localparam logic [7:0] AWSC_OFS_STATUS = 8'h08;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int AWSC_A1_LSB = 6;   // area1_wait_field at 8:6
  localparam int AWSC_A2_LSB = 9;   // area2_wait_field at 11:9
  localparam int AWSC_A3_LSB = 13;  // area3_wait_field at 15:13
  localparam logic [31:0] AWSC_WAIT_RST  = 32'h0000efc0;
  localparam logic [31:0] AWSC_WAIT_MASK = 32'h0000efc0;
  localparam logic [31:0] AWSC_MODE_RST  = 32'h00000000;
  localparam logic [31:0] AWSC_MODE_MASK = 32'h0000013d;
  localparam int AWSC_MODE_RASDN = 8;  // Row address held down mode
  localparam int AWSC_STAT_ERR   = 8;  // Sticky prohibited code flag

  // ************************************************************
  // Interface type codes and engine states
  // ************************************************************
  typedef enum logic [1:0] {
    AWSC_IF_SRAM  = 2'b00,
    AWSC_IF_MPX   = 2'b01,
    AWSC_IF_DRAM  = 2'b10,
    AWSC_IF_SDRAM = 2'b11
  } awsc_if_e;

  typedef enum logic [0:0] {
    AWSC_ST_IDLE  = 1'b0,
    AWSC_ST_COUNT = 1'b1
  } awsc_state_e;

  // Step by which the access engine counts its wait cycle counter down
  localparam logic [4:0] AWSC_ONE = 5'h01;

endpackage

// ===== verilog/awsc_decode.sv
// Decoder from a 3-bit wait field to a cycle count and ready usage
module awsc_decode
  import awsc_pkg::*;
(
  // Configuration of the selected area
  input  wire logic [2:0]        field,
  input  wire awsc_pkg::awsc_if_e itype,
  input  wire logic              rasdn,
  // Access attributes
  input  wire logic              is_write,
  input  wire logic              later,
  // Decoded result
  output logic [4:0]             count,
  output logic                   honour,
  output logic                   strobe,
  output logic                   prohibited
);

  // ************************************************************
  // Look-up of the documented code tables
  // ************************************************************
  logic [4:0] sram_waits;
  logic [4:0] mpx_waits;
  logic       sdram_bad;

  // Eight-value first cycle wait table
  always_comb begin
    case (field)
      3'h0: sram_waits = 5'h00;
      3'h1: sram_waits = 5'h01;
      3'h2: sram_waits = 5'h02;
      3'h3: sram_waits = 5'h03;
      3'h4: sram_waits = 5'h06;
      3'h5: sram_waits = 5'h09;
      3'h6: sram_waits = 5'h0c;
      default: sram_waits = 5'h0f;
    endcase
  end

  // Multiplexed bus waits: low bits for first data, top bit for later
  assign mpx_waits = later ? {4'h0, field[2]} :
                     (!is_write && field[1:0] == 2'h0) ? 5'h01 :
                     {3'h0, field[1:0]};

  // Latency codes 0, 6, 7 barred; 1, 4, 5 barred in row held down mode
  assign sdram_bad = (field == 3'h0) || (field > 3'h5) ||
                     (rasdn && (field == 3'h1 || field == 3'h4 ||
                                field == 3'h5));

  // Selection by interface type
  always_comb begin
    count      = sram_waits;
    honour     = (field != 3'h0);
    strobe     = 1'b0;
    prohibited = 1'b0;
    case (itype)
      AWSC_IF_MPX: begin
        count  = mpx_waits;
        honour = 1'b1;
      end
      AWSC_IF_DRAM: begin
        count  = sram_waits;  // Width minus one: 1,2,3,4,7,10,13,16
        honour = 1'b0;
        strobe = 1'b1;
      end
      AWSC_IF_SDRAM: begin
        count      = sdram_bad ? 5'h00 : {2'h0, field};
        honour     = 1'b0;
        prohibited = sdram_bad;
      end
      default: begin
        count  = sram_waits;
        honour = (field != 3'h0);
      end
    endcase
  end

endmodule // awsc_decode

// ===== verilog/awsc_top.sv
// Wait state control for external areas 1 to 3 with a Wishbone slave
//
// The Wishbone slave port and the address map are this design's own decisions.
module awsc_top
  import awsc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Access request from the bus controller
  input  wire logic        acc_start,
  input  wire logic [1:0]  acc_area,
  input  wire logic        acc_write,
  input  wire logic        acc_later,
  // External memory side
  input  wire logic        ext_ready,
  output logic             acc_busy,
  output logic             acc_done,
  output logic             acc_strobe
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [31:0] wait_reg, wait_next;
  logic [31:0] mode_reg, mode_next;
  logic        err_reg, err_next;
  logic        ack_reg;
  logic [31:0] dat_reg;

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire logic        bus_req  = wb_cyc_i && wb_stb_i && !ack_reg;
  wire logic        bus_wr   = bus_req && wb_we_i;
  wire logic        hit_wait = (wb_adr_i == AWSC_OFS_WAIT);
  wire logic        hit_mode = (wb_adr_i == AWSC_OFS_MODE);
  wire logic        hit_stat = (wb_adr_i == AWSC_OFS_STATUS);
  wire logic [31:0] sel_mask;

  // Byte lane mask from the select lines
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign sel_mask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  // Masked merge of write data into a register
  function automatic logic [31:0] awsc_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [31:0] lane,
                                             input logic [31:0] keep);
    awsc_merge = ((old & ~lane) | (wd & lane)) & keep;
  endfunction

  // ************************************************************
  // Per area fields and effective types
  // ************************************************************
  logic [2:0] area_field [1:3];
  awsc_if_e   area_type  [1:3];
  wire logic  rasdn = mode_reg[AWSC_MODE_RASDN];

  // Field slices; area 1 only knows SRAM or multiplexed
  assign area_field[1] = wait_reg[AWSC_A1_LSB +: 3];
  assign area_field[2] = wait_reg[AWSC_A2_LSB +: 3];
  assign area_field[3] = wait_reg[AWSC_A3_LSB +: 3];
  assign area_type[1]  = awsc_if_e'({1'b0, mode_reg[0]});
  assign area_type[2]  = (mode_reg[3:2] == AWSC_IF_DRAM) ? AWSC_IF_SRAM :
                         awsc_if_e'(mode_reg[3:2]);
  assign area_type[3]  = awsc_if_e'(mode_reg[5:4]);

  // Selected area; area 0 falls outside this block
  wire logic       area_ok  = (acc_area != 2'h0);
  wire logic [2:0] sel_fld  = area_ok ? area_field[acc_area] : 3'h0;
  wire awsc_if_e   sel_type = area_ok ? area_type[acc_area] : AWSC_IF_SRAM;

  logic [4:0] dec_count;
  logic       dec_honour;
  logic       dec_strobe;
  logic       dec_bad;

  // Table decode of the selected area
  awsc_decode u_decode (
    .field      (sel_fld),
    .itype      (sel_type),
    .rasdn      (rasdn),
    .is_write   (acc_write),
    .later      (acc_later),
    .count      (dec_count),
    .honour     (dec_honour),
    .strobe     (dec_strobe),
    .prohibited (dec_bad)
  );

  // ************************************************************
  // Access engine
  // ************************************************************
  awsc_state_e state_reg, state_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic        honour_reg, honour_next;
  logic        strobe_reg, strobe_next;
  logic        done_next;

  wire logic take   = (state_reg == AWSC_ST_IDLE) && acc_start;
  wire logic finish = (state_reg == AWSC_ST_COUNT) && (cnt_reg == 5'h00) &&
                      (!honour_reg || ext_ready);
  wire logic set_err = take && area_ok && dec_bad;

  // Next state: the config is latched only when an access starts
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    honour_next = honour_reg;
    strobe_next = strobe_reg;
    done_next   = 1'b0;
    case (state_reg)
      AWSC_ST_IDLE: begin
        if (take) begin
          state_next  = AWSC_ST_COUNT;
          cnt_next    = dec_count;
          honour_next = area_ok && dec_honour;
          strobe_next = area_ok && dec_strobe;
        end
      end
      AWSC_ST_COUNT: begin
        if (cnt_reg != 5'h00) begin
          cnt_next = cnt_reg - AWSC_ONE;
        end else if (finish) begin
          state_next  = AWSC_ST_IDLE;
          strobe_next = 1'b0;
          done_next   = 1'b1;
        end
      end
      default: begin
        state_next = AWSC_ST_IDLE;
      end
    endcase
  end

  // Engine flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg  <= AWSC_ST_IDLE;
      cnt_reg    <= 5'h00;
      honour_reg <= 1'b0;
      strobe_reg <= 1'b0;
      acc_done   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      honour_reg <= honour_next;
      strobe_reg <= strobe_next;
      acc_done   <= done_next;
    end
  end

  assign acc_busy   = (state_reg == AWSC_ST_COUNT);
  assign acc_strobe = strobe_reg;

  // ************************************************************
  // Register writes and status
  // ************************************************************
  wire logic clr_err = bus_wr && hit_stat && wb_sel_i[1] &&
                       wb_dat_i[AWSC_STAT_ERR];

  // Register next values; an error event wins over its clear
  assign wait_next = (bus_wr && hit_wait) ?
                     awsc_merge(wait_reg, wb_dat_i, sel_mask,
                                AWSC_WAIT_MASK) : wait_reg;
  assign mode_next = (bus_wr && hit_mode) ?
                     awsc_merge(mode_reg, wb_dat_i, sel_mask,
                                AWSC_MODE_MASK) : mode_reg;
  assign err_next  = set_err || (err_reg && !clr_err);

  wire logic [31:0] stat_word = {23'h0, err_reg, cnt_reg, state_reg,
                                 strobe_reg, honour_reg};
  wire logic [31:0] rd_word   = hit_wait ? wait_reg :
                                hit_mode ? mode_reg :
                                hit_stat ? stat_word : 32'h00000000;

  // Register flops and bus answer one cycle after the request
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= AWSC_WAIT_RST;
      mode_reg <= AWSC_MODE_RST;
      err_reg  <= 1'b0;
      ack_reg  <= 1'b0;
      dat_reg  <= 32'h00000000;
    end else begin
      wait_reg <= wait_next;
      mode_reg <= mode_next;
      err_reg  <= err_next;
      ack_reg  <= bus_req;
      dat_reg  <= bus_req ? rd_word : dat_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

endmodule // awsc_top

// ===== verification/awsc_props.sv
// Checker of bus and access timing at the block ports
module awsc_props (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Access engine
  input wire logic        acc_start,
  input wire logic [1:0]  acc_area,
  input wire logic        acc_busy,
  input wire logic        acc_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ************
  // Bus timing
  // ************
  chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack not one cycle after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack wider than one cycle");
  chk_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_rdata_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o)
    |=> $stable(wb_dat_o)) else $error("read data moved while idle");
  // ***************
  // Access timing
  // ***************
  chk_done_pulse: assert property (acc_done |=> !acc_done)
    else $error("done wider than one cycle");
  chk_start_busy: assert property (acc_start && !acc_busy
    && acc_area != 2'h0 |=> acc_busy) else $error("start not taken");
  chk_busy_done: assert property ($fell(acc_busy) |-> acc_done)
    else $error("busy ended without done");
  chk_done_idle: assert property (acc_done |-> !acc_busy)
    else $error("done while busy");
endmodule // awsc_props

bind awsc_top awsc_props awsc_props_inst (.core_clk(core_clk),
  .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .acc_start(acc_start),
  .acc_area(acc_area), .acc_busy(acc_busy), .acc_done(acc_done));

// ===== verification/awsc_mem_model.sv
// Memory side model holding ready low for a set number of cycles
module awsc_mem_model (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       resetn,
  // Access state and stall length
  input wire logic       acc_busy,
  input wire logic [4:0] stall,
  // Ready toward the block
  output logic           ext_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_reg;
  // Count busy cycles of the current access
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) cnt_reg <= 5'h00;
    else if (!acc_busy) cnt_reg <= 5'h00;
    else if (cnt_reg != 5'h1f) cnt_reg <= cnt_reg + 5'h01;
  end
  // Ready once the stall has run out
  assign ext_ready = !acc_busy || (cnt_reg >= stall);
endmodule // awsc_mem_model

// ===== verification/awsc_tb_top.sv
// Self-checking bench for the area wait state control block
module awsc_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import awsc_pkg::*;
  logic        clk, rstn, cyc, stb, we, ack, rdy;
  logic        start, wr, busy, done, strb, lat, lat_sel;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  logic [1:0]  area;
  logic [4:0]  stall;
  int          mismatches, checks_done;
  int wt[8] = '{0, 1, 2, 3, 6, 9, 12, 15};
  int dw[8] = '{1, 2, 3, 4, 7, 10, 13, 16};
  awsc_top awsc_top_inst (.core_clk(clk), .resetn(rstn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .acc_start(start), .acc_area(area), .acc_write(wr),
    .acc_later(lat), .ext_ready(rdy), .acc_busy(busy),
    .acc_done(done), .acc_strobe(strb));
  awsc_mem_model awsc_mem_model_inst (.core_clk(clk), .resetn(rstn),
    .acc_busy(busy), .stall(stall), .ext_ready(rdy));
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    tally_and_finish();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  // One classic bus cycle, held until ack
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) hang();
  endtask
  task automatic setw(input logic [2:0] c);
    logic [31:0] q;
    bus(1'b1, AWSC_OFS_WAIT, {16'h0000, c, 1'b0, c, c, 6'h00}, q);
  endtask
  // One access; counts busy and strobe cycles until done
  task automatic acc(input logic [1:0] ar, input logic w,
                     input logic [4:0] st, output int nb, ns);
    int n;
    nb = 0;
    ns = 0;
    n = 0;
    @(posedge clk);
    start <= 1'b1;
    area <= ar;
    wr <= w;
    lat <= lat_sel;
    stall <= st;
    @(posedge clk);
    start <= 1'b0;
    do begin
      @(negedge clk);
      nb += int'(busy === 1'b1);
      ns += int'(strb === 1'b1);
      n++;
    end while (done !== 1'b1 && n < 60);
    if (done !== 1'b1) hang();
  endtask
  // ***********
  // Scenarios
  // ***********
  task automatic t_regs();
    logic [31:0] q;
    bus(1'b0, AWSC_OFS_WAIT, 32'h0, q);
    chk("wait reset", AWSC_WAIT_RST, q);
    bus(1'b0, AWSC_OFS_MODE, 32'h0, q);
    chk("mode reset", AWSC_MODE_RST, q);
    bus(1'b1, AWSC_OFS_WAIT, 32'hffffffff, q);
    bus(1'b0, AWSC_OFS_WAIT, 32'h0, q);
    chk("wait mask", AWSC_WAIT_MASK, q);
    bus(1'b1, 8'h0c, 32'hffffffff, q);
    bus(1'b0, 8'h0c, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic t_sram();
    int nb, ns;
    for (int a = 1; a < 4; a++) begin
      for (int c = 0; c < 8; c++) begin
        setw(3'(c));
        acc(2'(a), 1'b0, 5'h00, nb, ns);
        chk("sram busy", wt[c] + 1, nb);
      end
    end
    setw(3'h0);
    acc(2'h1, 1'b0, 5'h1f, nb, ns);
    chk("ready ignored", 1, nb);
    setw(3'h1);
    acc(2'h3, 1'b0, 5'h05, nb, ns);
    chk("ready stall", 6, nb);
  endtask
  task automatic t_dram();
    int nb, ns;
    logic [31:0] q;
    bus(1'b1, AWSC_OFS_MODE, 32'h20, q);
    for (int c = 0; c < 8; c++) begin
      setw(3'(c));
      acc(2'h3, 1'b0, 5'h1f, nb, ns);
      chk("dram strobe", dw[c], ns);
    end
  endtask
  task automatic t_sdram();
    int nb, ns;
    logic bad;
    logic [31:0] q;
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, AWSC_OFS_MODE, m ? 32'h13c : 32'h3c, q);
      for (int a = 2; a < 4; a++) begin
        for (int c = 0; c < 8; c++) begin
          bad = c == 0 || c > 5 || (m == 1 && (c == 1 || c > 3));
          setw(3'(c));
          acc(2'(a), 1'b0, 5'h1f, nb, ns);
          chk("sdram busy", bad ? 1 : c + 1, nb);
          bus(1'b0, AWSC_OFS_STATUS, 32'h0, q);
          chk("code error", 32'(bad), 32'(q[8]));
          bus(1'b1, AWSC_OFS_STATUS, 32'h100, q);
        end
      end
    end
  endtask
  task automatic t_mpx();
    int nb, ns;
    logic [31:0] q;
    bus(1'b1, AWSC_OFS_MODE, 32'h15, q);
    for (int a = 1; a < 4; a++) begin
      setw(3'h0);
      acc(2'(a), 1'b0, 5'h03, nb, ns);
      chk("mpx read", 4, nb);
      acc(2'(a), 1'b1, 5'h00, nb, ns);
      chk("mpx write", 1, nb);
      setw(3'h3);
      lat_sel = 1'b1;
      acc(2'(a), 1'b0, 5'h00, nb, ns);
      chk("mpx later low", 1, nb);
      setw(3'h7);
      acc(2'(a), 1'b0, 5'h00, nb, ns);
      chk("mpx later high", 2, nb);
      lat_sel = 1'b0;
      acc(2'(a), 1'b1, 5'h00, nb, ns);
      chk("mpx write top", 4, nb);
    end
    bus(1'b1, AWSC_OFS_MODE, 32'h08, q);
    bus(1'b0, AWSC_OFS_MODE, 32'h0, q);
    chk("mode readback", 32'h08, q);
    setw(3'h1);
    acc(2'h2, 1'b0, 5'h05, nb, ns);
    chk("area2 type 10", 6, nb);
  endtask
  // Field rewritten while an access runs only affects the next one
  task automatic t_latch();
    int nb, ns;
    logic [31:0] q;
    bus(1'b1, AWSC_OFS_MODE, 32'h0, q);
    setw(3'h7);
    fork
      acc(2'h1, 1'b0, 5'h00, nb, ns);
      setw(3'h0);
    join
    chk("old field kept", 16, nb);
    acc(2'h1, 1'b0, 5'h00, nb, ns);
    chk("new field used", 1, nb);
  endtask
  // Clock, reset and main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rstn, cyc, stb, we, start, wr, lat, lat_sel} = '0;
    {adr, wdat, area, stall} = '0;
    mismatches = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_sram();
    t_dram();
    t_sdram();
    t_mpx();
    t_latch();
    tally_and_finish();
  end
endmodule // awsc_tb_top
